/* tse_pkg.sv */
// constants and types for the trap syndrome encoder
package tse_pkg;
  // exception classes
  localparam logic [5:0] CLS_LDST = 6'h06;
  localparam logic [5:0] CLS_FP = 6'h07;
  localparam logic [5:0] CLS_VEC = 6'h19;
  localparam logic [5:0] CLS_NONE = 6'h00;
  // field values
  localparam logic [3:0] CODE_FIELD_A_ALWAYS = 4'hE;
  localparam logic [3:0] REG_PC32 = 4'hF;
  localparam logic [4:0] REG_ZR64 = 5'h1F;
  // syndrome field positions
  localparam int SYN_VALID = 24;
  localparam int CODE_FIELD_A_HI = 23;
  localparam int CODE_FIELD_A_LO = 20;
  localparam int IMM_HI = 19;
  localparam int IMM_LO = 12;
  localparam int RSV_HI = 11;
  localparam int RSV_LO = 10;
  localparam int BASE_HI = 9;
  localparam int BASE_LO = 5;
  localparam int UP_BIT = 4;
  localparam int AM_HI = 3;
  localparam int AM_LO = 1;
  localparam int DIR_BIT = 0;
  localparam int AM_FORM = 2;
  // register map, byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SYND = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam int CTRL_PASS_OWN = 0;
  localparam int CTRL_FP_PRES = 1;
  localparam int CTRL_VEC_PRES = 2;
  localparam logic [2:0] CTRL_RST = 3'b110;
  localparam int STAT_VALID = 0;
  localparam int STAT_LVL_LO = 1;
  localparam logic [1:0] LVL_ONE = 2'h1;
  localparam logic [1:0] LVL_TWO = 2'h2;
  localparam logic [1:0] LVL_THREE = 2'h3;

  typedef enum logic [1:0] {
    KIND_LDST = 2'h0,
    KIND_FP = 2'h1,
    KIND_VEC = 2'h2,
    KIND_ILL = 2'h3
  } tse_kind_type;

  typedef enum logic [1:0] {
    ST_EMPTY = 2'b01,
    ST_HELD = 2'b10
  } tse_state_type;

  typedef struct packed {
    tse_kind_type kind;
    logic from_wide;
    logic compact;
    logic conditional;
    logic known_pass;
    logic [3:0] code_field_a;
    logic [7:0] imm_byte;
    logic [3:0] base;
    logic unpred;
    logic up;
    logic literal;
    logic pre;
    logic wback;
    logic load;
    logic [5:0] ill_class;
    logic [1:0] cur_level;
  } tse_trap_type;

  typedef struct packed {
    logic [5:0] cls;
    logic [24:0] info;
  } tse_synd_type;
endpackage : tse_pkg

/* tse_trap_syndrome_encoder.sv */
// trap syndrome encoder with wishbone register access
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module tse_trap_syndrome_encoder
  import tse_pkg::*;
#(
  parameter bit COMPACT_CV = 1'b1
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic trap_take,
  input wire tse_trap_type trap_info,
  input wire logic debug_comms_trap,
  input wire logic debug_comms_to_two,
  input wire logic debug_access_trap_two,
  input wire logic debug_access_trap_three,
  output tse_synd_type syndrome_info,
  output logic syndrome_valid,
  output logic [1:0] route_level
);

  ////////////////////////////////////////////////////////////////////////
  // condition pair shared by load/store and fp encodings
  function automatic logic [4:0] code_field_a_pair(
    input tse_trap_type t,
    input logic pass_own
  );
    logic [4:0] r;
    r = {1'b1, CODE_FIELD_A_ALWAYS};
    if (t.from_wide)
    begin
      r = {1'b1, CODE_FIELD_A_ALWAYS};
    end
    else if (t.compact)
    begin
      // fixed per build; software then reads the saved it state
      r = code_field_a_applies(t, COMPACT_CV);
    end
    else if (t.conditional && !(t.known_pass && !pass_own))
    begin
      r = {1'b1, t.code_field_a};
    end
    return r;
  endfunction : code_field_a_pair

  function automatic logic [4:0] code_field_a_applies(
    input tse_trap_type t,
    input logic valid_bit
  );
    logic [4:0] r;
    r = {valid_bit, t.conditional ? t.code_field_a : CODE_FIELD_A_ALWAYS};
    return r;
  endfunction : code_field_a_applies

  ////////////////////////////////////////////////////////////////////////
  // registers
  tse_state_type state_reg;
  tse_state_type state_next;
  tse_synd_type synd_reg;
  tse_synd_type synd_next;
  logic [2:0] ctrl_reg;
  logic [2:0] ctrl_next;
  logic [1:0] level_reg;
  logic [1:0] level_next;
  logic ack_reg;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic bus_req = wb_cyc && wb_stb && !ack_reg;
  wire logic bus_wr = bus_req && wb_we && wb_sel[0];
  wire logic hit_ctrl = wb_adr == ADR_CTRL;
  wire logic hit_synd = wb_adr == ADR_SYND;
  wire logic hit_stat = wb_adr == ADR_STAT;
  wire logic wr_ctrl = bus_wr && hit_ctrl;
  wire logic clr_valid = bus_wr && hit_stat && wb_dat_w[STAT_VALID];
  wire logic [31:0] rd_ctrl = {29'h0, ctrl_reg};
  wire logic [31:0] rd_synd = {1'b0, synd_reg};
  wire logic [31:0] rd_stat = {29'h0, level_reg, state_reg == ST_HELD};
  wire logic [31:0] rd_data = hit_ctrl ? rd_ctrl :
                              hit_synd ? rd_synd :
                              hit_stat ? rd_stat : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // syndrome assembly
  wire logic pass_own = ctrl_reg[CTRL_PASS_OWN];
  wire logic fp_pres = ctrl_reg[CTRL_FP_PRES];
  wire logic vec_pres = ctrl_reg[CTRL_VEC_PRES];
  wire logic [4:0] valid_code_field_a = code_field_a_pair(trap_info, pass_own);

  // literal form exists only for full-set loads
  wire logic lit_ok = trap_info.load && !trap_info.compact;
  wire logic am_form = trap_info.literal && lit_ok;
  // literal forms carry no write-back, which keeps 101/111 out
  wire logic am_wb = trap_info.wback && !am_form;
  wire logic [2:0] am_val = {am_form, trap_info.pre, am_wb};

  // pc as base maps to the wide zero register view
  wire logic base_pc = trap_info.base == REG_PC32;
  // unpredictable case takes the same value as the defined one
  wire logic [4:0] base_val = base_pc ? REG_ZR64 :
                              {1'b0, trap_info.base};
  // literal form still copies the field; software ignores it
  wire logic [4:0] base_rep = base_val;

  logic [24:0] syn_ldst;
  always_comb
  begin
    syn_ldst = '0;
    syn_ldst[SYN_VALID] = valid_code_field_a[4];
    syn_ldst[CODE_FIELD_A_HI:CODE_FIELD_A_LO] = valid_code_field_a[3:0];
    syn_ldst[IMM_HI:IMM_LO] = trap_info.imm_byte;
    syn_ldst[RSV_HI:RSV_LO] = 2'b00;
    syn_ldst[BASE_HI:BASE_LO] = base_rep;
    syn_ldst[UP_BIT] = trap_info.up;
    syn_ldst[AM_HI:AM_LO] = am_val;
    syn_ldst[DIR_BIT] = trap_info.load;
  end

  wire logic [24:0] syn_fp = {valid_code_field_a, 20'h0_0000};
  // fp traps take class CLS_FP unless fp and vector are both absent; vector traps take CLS_VEC only when vector is present, else CLS_NONE
  wire logic fp_kind = trap_info.kind == KIND_FP;
  wire logic fp_none = !fp_pres && !vec_pres;
  wire logic [5:0] cls_fp = fp_none ? CLS_NONE : CLS_FP;
  wire logic [5:0] cls_vec = vec_pres ? CLS_VEC : CLS_NONE;

  always_comb
  begin
    synd_next = synd_reg;
    if (trap_take)
    begin
      case (trap_info.kind)
        KIND_LDST: synd_next = '{cls: CLS_LDST, info: syn_ldst};
        KIND_FP: synd_next = '{cls: cls_fp, info: syn_fp};
        KIND_VEC: synd_next = '{cls: cls_vec, info: 25'h000_0000};
        KIND_ILL: synd_next = '{cls: trap_info.ill_class, info: 25'h000_0000};
        default: synd_next = synd_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // debug data register routing, lowest enabled level wins
  wire logic lvl_le_one = trap_info.cur_level <= LVL_ONE;
  wire logic lvl_le_two = trap_info.cur_level <= LVL_TWO;
  wire logic [1:0] comms_lvl = debug_comms_to_two ? LVL_TWO : LVL_ONE;
  wire logic use_comms = debug_comms_trap && lvl_le_one;
  wire logic use_two = debug_access_trap_two && lvl_le_two;
  wire logic [1:0] route_calc = use_comms ? comms_lvl :
                                use_two ? LVL_TWO :
                                debug_access_trap_three ? LVL_THREE :
                                trap_info.cur_level;
  wire logic ldst_take = trap_take && trap_info.kind == KIND_LDST;

  always_comb
  begin
    level_next = ldst_take ? route_calc : level_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // holding state; a new trap wins over a software clear
  always_comb
  begin
    case (state_reg)
      ST_EMPTY: state_next = trap_take ? ST_HELD : ST_EMPTY;
      ST_HELD: state_next = (clr_valid && !trap_take) ? ST_EMPTY : ST_HELD;
      default: state_next = ST_EMPTY;
    endcase
  end

  always_comb
  begin
    ctrl_next = wr_ctrl ? wb_dat_w[2:0] : ctrl_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // flops
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_EMPTY;
      ctrl_reg <= CTRL_RST;
      level_reg <= LVL_ONE;
      ack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      level_reg <= level_next;
      ack_reg <= bus_req;
    end
  end

  // zero is one legal unknown value; keeps outputs defined
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      synd_reg <= '0;
    end
    else
    begin
      synd_reg <= synd_next;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wb_dat_r <= 32'h0000_0000;
    end
    else if (bus_req)
    begin
      wb_dat_r <= rd_data;
    end
  end

  assign wb_ack = ack_reg;
  assign syndrome_info = synd_reg;
  assign syndrome_valid = state_reg == ST_HELD;
  assign route_level = level_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  wire logic t_code_field_a = trap_take && trap_info.kind inside {KIND_LDST, KIND_FP};
  wire logic t_full = t_code_field_a && !trap_info.from_wide && !trap_info.compact;

  wide_code_field_a_a: assert property (
    t_code_field_a && trap_info.from_wide |=>
    syndrome_info.info[SYN_VALID] && syndrome_info.info[CODE_FIELD_A_HI:CODE_FIELD_A_LO] == CODE_FIELD_A_ALWAYS)
    else $error("wide trap condition not always");

  full_code_field_a_a: assert property (
    t_full && trap_info.conditional && !trap_info.known_pass |=>
    syndrome_info.info[CODE_FIELD_A_HI:CODE_FIELD_A_LO] == $past(trap_info.code_field_a))
    else $error("full trap condition code not copied");

  pass_code_a: assert property (
    t_full && trap_info.conditional && trap_info.known_pass |=>
    syndrome_info.info[CODE_FIELD_A_HI:CODE_FIELD_A_LO] == ($past(pass_own) ? $past(trap_info.code_field_a) : CODE_FIELD_A_ALWAYS))
    else $error("known-pass condition code wrong");

  compact_valid_a: assert property (
    t_code_field_a && !trap_info.from_wide && trap_info.compact |=>
    syndrome_info.info[SYN_VALID] == COMPACT_CV)
    else $error("compact trap valid flag not the fixed choice");

  valid_flag_a: assert property (
    t_full |=> syndrome_info.info[SYN_VALID] && syndrome_valid)
    else $error("condition valid flag not set");

  imm_field_a: assert property (
    ldst_take |=> syndrome_info.info[IMM_HI:IMM_LO] == $past(trap_info.imm_byte)
    && syndrome_info.info[RSV_HI:RSV_LO] == 2'b00)
    else $error("immediate byte field wrong");

  base_pc_a: assert property (
    ldst_take && trap_info.base == REG_PC32 |=>
    syndrome_info.info[BASE_HI:BASE_LO] == REG_ZR64)
    else $error("pc base not mapped to zero register view");

  am_legal_a: assert property (
    syndrome_info.cls == CLS_LDST && syndrome_valid |->
    syndrome_info.info[AM_HI:AM_LO] != 3'b101
    && syndrome_info.info[AM_HI:AM_LO] != 3'b111
    && (syndrome_info.info[DIR_BIT] || !syndrome_info.info[AM_HI]))
    else $error("reserved addressing mode reported");

  dir_bit_a: assert property (
    ldst_take |=> syndrome_info.info[DIR_BIT] == $past(trap_info.load)
    && syndrome_info.cls == CLS_LDST)
    else $error("direction bit wrong");

  fp_zero_a: assert property (
    trap_take && fp_kind && fp_pres |=>
    syndrome_info.cls == CLS_FP && syndrome_info.info[IMM_HI:0] == 20'h0_0000)
    else $error("fp syndrome wrong");

  fp_absent_a: assert property (
    trap_take && fp_kind && !fp_pres && !vec_pres |=>
    syndrome_info.cls == CLS_NONE)
    else $error("fp trap class not zero when absent");

  vec_zero_a: assert property (
    trap_take && trap_info.kind == KIND_VEC && vec_pres |=>
    syndrome_info.cls == CLS_VEC && syndrome_info.info == 25'h000_0000)
    else $error("vector syndrome wrong");

  ill_zero_a: assert property (
    trap_take && trap_info.kind == KIND_ILL |=>
    syndrome_info.info == 25'h000_0000 && syndrome_info.cls == $past(trap_info.ill_class))
    else $error("illegal state syndrome not zero");

  synd_stable_a: assert property (
    !trap_take |=> $stable(syndrome_info))
    else $error("syndrome changed without a trap");

  route_three_a: assert property (
    ldst_take && !debug_comms_trap && !debug_access_trap_two
    && debug_access_trap_three |=> route_level == LVL_THREE)
    else $error("debug trap not routed to level three");

  route_comms_a: assert property (
    ldst_take && debug_comms_trap && trap_info.cur_level <= LVL_ONE |=>
    route_level == ($past(debug_comms_to_two) ? LVL_TWO : LVL_ONE))
    else $error("comms trap not routed to level one or two");

endmodule : tse_trap_syndrome_encoder

/* tse_trap_syndrome_encoder_test.sv */
// self-checking bench for the trap syndrome encoder
`timescale 1ns/1ps
module tse_trap_syndrome_encoder_test;
  import tse_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic trap_take = 1'b0;
  tse_trap_type trap_info = '0;
  // routing controls: comms trap, comms to two, access trap two, access trap three
  logic [3:0] rctl = 4'h0;
  tse_synd_type syndrome_info;
  logic syndrome_valid;
  logic [1:0] route_level;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  tse_trap_type t;

  always #12.5 ref_clk = ~ref_clk;

  tse_trap_syndrome_encoder #(.COMPACT_CV(1'b1)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .trap_take(trap_take), .trap_info(trap_info), .debug_comms_trap(rctl[3]),
    .debug_comms_to_two(rctl[2]), .debug_access_trap_two(rctl[1]), .debug_access_trap_three(rctl[0]),
    .syndrome_info(syndrome_info), .syndrome_valid(syndrome_valid), .route_level(route_level));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20)
      fail_count++;
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic trap(input tse_trap_type info);
    @(posedge ref_clk);
    trap_take <= 1'b1;
    trap_info <= info;
    @(posedge ref_clk);
    trap_take <= 1'b0;
    @(posedge ref_clk);
  endtask : trap

  function automatic tse_trap_type mk(input tse_kind_type k);
    mk = '0;
    mk.kind = k;
  endfunction : mk

  function automatic logic [24:0] ls(input logic [3:0] c, input logic [7:0] i, input logic [4:0] b,
    input logic u, input logic [2:0] am, input logic d);
    ls = {1'b1, c, i, 2'b00, b, u, am, d};
  endfunction : ls

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    wb(1'b0, ADR_CTRL, 32'h0000_0000);
    check("ctrl reset", rd, 32'h0000_0006);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    check("unmapped read", rd, 32'h0000_0000);
    wb(1'b0, ADR_CTRL, 32'h0000_0000);
    check("ctrl after unmapped write", rd, 32'h0000_0006);
    // a write without byte lane 0 must not touch the control bits
    wb_sel <= 4'hE;
    wb(1'b1, ADR_CTRL, 32'h0000_0001);
    wb_sel <= 4'hF;
    wb(1'b0, ADR_CTRL, 32'h0000_0000);
    check("ctrl after masked write", rd, 32'h0000_0006);
  endtask : test_regs

  task automatic test_ldst();
    t = mk(KIND_LDST);
    t.from_wide = 1'b1;
    t.conditional = 1'b1;
    t.code_field_a = 4'h3;
    t.imm_byte = 8'hA5;
    t.base = 4'h3;
    t.up = 1'b1;
    t.pre = 1'b1;
    t.wback = 1'b1;
    t.load = 1'b1;
    trap(t);
    check("wide load", {1'b0, syndrome_info}, {1'b0, CLS_LDST, ls(4'hE, 8'hA5, 5'h03, 1'b1, 3'b011, 1'b1)});
    check("valid", {31'h0000_0000, syndrome_valid}, 32'h0000_0001);
    t = mk(KIND_LDST);
    t.conditional = 1'b1;
    t.code_field_a = 4'h5;
    t.imm_byte = 8'h0F;
    t.base = REG_PC32;
    t.pre = 1'b1;
    trap(t);
    check("full store", {1'b0, syndrome_info}, {1'b0, CLS_LDST, ls(4'h5, 8'h0F, 5'h1F, 1'b0, 3'b010, 1'b0)});
    t = mk(KIND_LDST);
    t.base = REG_PC32;
    t.unpred = 1'b1;
    t.literal = 1'b1;
    t.wback = 1'b1;
    t.up = 1'b1;
    t.load = 1'b1;
    trap(t);
    check("literal load", {1'b0, syndrome_info}, {1'b0, CLS_LDST, ls(4'hE, 8'h00, 5'h1F, 1'b1, 3'b100, 1'b1)});
    // compact loads must never show the literal form
    t = mk(KIND_LDST);
    t.compact = 1'b1;
    t.literal = 1'b1;
    t.base = 4'h2;
    t.load = 1'b1;
    trap(t);
    check("compact load", {1'b0, syndrome_info}, {1'b0, CLS_LDST, ls(4'hE, 8'h00, 5'h02, 1'b0, 3'b000, 1'b1)});
  endtask : test_ldst

  task automatic test_fp();
    t = mk(KIND_FP);
    t.conditional = 1'b1;
    t.known_pass = 1'b1;
    t.code_field_a = 4'h1;
    trap(t);
    check("fp pass always", {1'b0, syndrome_info}, {1'b0, CLS_FP, 1'b1, CODE_FIELD_A_ALWAYS, 20'h0_0000});
    wb(1'b1, ADR_CTRL, 32'h0000_0007);
    trap(t);
    check("fp pass own", {1'b0, syndrome_info}, {1'b0, CLS_FP, 1'b1, 4'h1, 20'h0_0000});
    t = mk(KIND_FP);
    t.compact = 1'b1;
    t.conditional = 1'b1;
    t.code_field_a = 4'hB;
    trap(t);
    check("fp compact", {1'b0, syndrome_info}, {1'b0, CLS_FP, 1'b1, 4'hB, 20'h0_0000});
    trap(mk(KIND_VEC));
    check("vector trap", {1'b0, syndrome_info}, {1'b0, CLS_VEC, 25'h000_0000});
    t = mk(KIND_ILL);
    t.ill_class = 6'h0E;
    t.imm_byte = 8'hFF;
    trap(t);
    check("illegal state", {1'b0, syndrome_info}, {1'b0, 6'h0E, 25'h000_0000});
    wb(1'b1, ADR_CTRL, 32'h0000_0000);
    trap(mk(KIND_FP));
    check("fp absent", {26'h000_0000, syndrome_info.cls}, {26'h000_0000, CLS_NONE});
    trap(mk(KIND_VEC));
    check("vector absent", {26'h000_0000, syndrome_info.cls}, {26'h000_0000, CLS_NONE});
    wb(1'b1, ADR_CTRL, 32'h0000_0006);
  endtask : test_fp

  task automatic test_route();
    logic [3:0] c [4] = '{4'b1000, 4'b1100, 4'b0010, 4'b0001};
    logic [1:0] l [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    logic [1:0] r [4] = '{LVL_ONE, LVL_TWO, LVL_TWO, LVL_THREE};
    for (int i = 0; i < 4; i++)
    begin
      rctl <= c[i];
      t = mk(KIND_LDST);
      t.cur_level = l[i];
      trap(t);
      wb(1'b0, ADR_STAT, 32'h0000_0000);
      check("status", rd, {29'h0000_0000, r[i], 1'b1});
      check("route level", {30'h0000_0000, route_level}, {30'h0000_0000, r[i]});
      wb(1'b1, ADR_STAT, 32'h0000_0001);
      wb(1'b0, ADR_STAT, 32'h0000_0000);
      check("status cleared", rd, {29'h0000_0000, r[i], 1'b0});
    end
    wb(1'b0, ADR_SYND, 32'h0000_0000);
    check("syndrome reg", rd, {1'b0, CLS_LDST, ls(4'hE, 8'h00, 5'h00, 1'b0, 3'b000, 1'b0)});
  endtask : test_route

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_regs();
    test_ldst();
    test_fp();
    test_route();
    print_verdict();
  end
endmodule : tse_trap_syndrome_encoder_test
